// ===== design/rx_timer_pkg.sv
`default_nettype none
package rx_timer_pkg;
  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_CORR2     = 8'h0D;
  localparam logic [7:0] IDX_MASK      = 8'h0F;
  localparam logic [7:0] IDX_NRT_HI    = 8'h10;
  localparam logic [7:0] IDX_NRT_LO    = 8'h11;
  localparam logic [7:0] IDX_TCTRL     = 8'h12;
  localparam logic [7:0] IDX_MODE      = 8'h18;
  localparam logic [7:0] IDX_STATUS    = 8'h19;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'h1A;
  localparam logic [7:0] IDX_COMMAND   = 8'h1B;
  localparam logic [7:0] IDX_STATE     = 8'h1C;
  // ---------------------------------------------------------------
  // reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] CORR2_RST     = 8'h00;
  localparam logic [7:0] MASK_RST      = 8'h08;
  localparam logic [7:0] NRT_RST       = 8'h00;
  localparam logic [7:0] TCTRL_RST     = 8'h00;
  localparam logic [7:0] MODE_RST      = 8'h00;
  localparam int STREAM_BIT     = 0;
  localparam int SLEEP_SEL_BIT  = 1;
  localparam int NRT_STEP_BIT   = 0;
  localparam int NRT_COND_BIT   = 2;
  localparam int MASK_STEP_BIT  = 3;
  localparam int MODE_NFC_BIT   = 0;
  localparam int MODE_ACTIVE_PEER_TO_PEER_MODE_BIT  = 1;
  localparam int MODE_SLOW_BIT  = 2;
  localparam int EV_NRT_BIT     = 0;
  localparam int EV_MASK_BIT    = 1;
  localparam int EV_SLEEP_BIT   = 2;
  localparam int CMD_NRT_BIT    = 0;
  localparam int EV_WIDTH       = 3;
  // ---------------------------------------------------------------
  // step sizes in carrier periods and clock timing
  // ---------------------------------------------------------------
  localparam logic [12:0] MASK_STEP_FINE   = 13'h0040;
  localparam logic [12:0] MASK_STEP_COARSE = 13'h0200;
  localparam logic [12:0] NRT_STEP_FINE    = 13'h0040;
  localparam logic [12:0] NRT_STEP_COARSE  = 13'h1000;
  localparam logic [16:0] CLK_KHZ          = 17'h1E848;
  localparam logic [16:0] FC_KHZ           = 17'h034F8;
  localparam int CLK_MHZ       = 125;
  localparam int SLEEP_IDLE_NS = 18000;
  localparam int EXIT_FAST_NS  = 18000;
  localparam int EXIT_SLOW_NS  = 42000;
  localparam int SLEEP_IDLE_CYCLES = (SLEEP_IDLE_NS * CLK_MHZ + 999) / 1000;
  localparam int EXIT_FAST_CYCLES  = (EXIT_FAST_NS * CLK_MHZ + 999) / 1000;
  localparam int EXIT_SLOW_CYCLES  = (EXIT_SLOW_NS * CLK_MHZ + 999) / 1000;
endpackage
`default_nettype wire

// ===== design/timer_if.sv
`default_nettype none
interface timer_if;
  logic        start;
  logic        abort;
  logic [12:0] stepLen;
  logic [15:0] value;
  logic        expire;
  logic        running;
  modport ctrl (output start, output abort, output stepLen, output value,
                input expire, input running);
  modport tmr  (input start, input abort, input stepLen, input value,
                output expire, output running);
endinterface
`default_nettype wire

// ===== design/step_timer.sv
`default_nettype none
module step_timer #(
  parameter int W = 16
) (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic fcTick,
  timer_if.tmr      t
);
  logic [W-1:0] remainQ;
  logic [12:0]  preQ;
  logic [12:0]  stepQ;
  logic         runQ;
  logic         expireQ;

  // value and step are latched at start so later writes wait for the next run
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      remainQ <= '0;
      preQ    <= 13'h0000;
      stepQ   <= 13'h0001;
      runQ    <= 1'b0;
      expireQ <= 1'b0;
    end
    else
    begin
      expireQ <= 1'b0;
      if (t.start)
      begin
        remainQ <= t.value[W-1:0];
        stepQ   <= t.stepLen;
        preQ    <= 13'h0000;
        runQ    <= 1'b1;
      end
      else if (t.abort)
        runQ <= 1'b0;
      else if (runQ && remainQ == '0)
      begin
        runQ    <= 1'b0;
        expireQ <= 1'b1;
      end
      else if (runQ && fcTick)
      begin
        if (preQ == stepQ - 13'h0001)
        begin
          preQ    <= 13'h0000;
          remainQ <= remainQ - 1'b1;
        end
        else
          preQ <= preQ + 13'h0001;
      end
    end

  assign t.expire  = expireQ;
  assign t.running = runQ;

  property p_single_expiry;
    @(posedge core_clk) disable iff (!reset_n) expireQ |-> !runQ ##1 !expireQ;
  endproperty
  a_single_expiry: assert property (p_single_expiry)
    else $error("timer expired twice in a row or kept running");
endmodule
`default_nettype wire

// ===== design/corr_sleep.sv
`default_nettype none
module corr_sleep #(
  parameter int EXIT_SLOW = rx_timer_pkg::EXIT_SLOW_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic corrPulse,
  input  wire logic rxEnable,
  input  wire logic exitSel,
  input  wire logic slowStd,
  output logic      sleeping,
  output logic      sleepEnter
);
  typedef enum logic [1:0] {AWAKE = 2'b01, ASLEEP = 2'b10} sleep_state_type;
  sleep_state_type stateQ;
  logic [12:0]     cntQ;
  logic [12:0]     exitLen;

  assign exitLen = slowStd ? 13'(EXIT_SLOW - 1) : 13'(rx_timer_pkg::EXIT_FAST_CYCLES - 1);

  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      stateQ     <= AWAKE;
      cntQ       <= 13'h0000;
      sleepEnter <= 1'b0;
    end
    else
    begin
      sleepEnter <= 1'b0;
      case (stateQ)
        AWAKE:
          if (corrPulse)
            cntQ <= 13'h0000;
          else if (cntQ == 13'(rx_timer_pkg::SLEEP_IDLE_CYCLES - 1))
          begin
            stateQ     <= ASLEEP;
            cntQ       <= 13'h0000;
            sleepEnter <= 1'b1;
          end
          else
            cntQ <= cntQ + 13'h0001;
        ASLEEP:
          if (exitSel)
          begin
            if (rxEnable)
            begin
              stateQ <= AWAKE;
              cntQ   <= 13'h0000;
            end
          end
          else if (cntQ == exitLen)
          begin
            stateQ <= AWAKE;
            cntQ   <= 13'h0000;
          end
          else
            cntQ <= cntQ + 13'h0001;
        default:
          stateQ <= AWAKE;
      endcase
    end

  assign sleeping = (stateQ == ASLEEP);

  property p_rx_wake_only;
    @(posedge core_clk) disable iff (!reset_n)
      sleeping && exitSel && !rxEnable |=> sleeping;
  endproperty
  a_rx_wake_only: assert property (p_rx_wake_only)
    else $error("sleep left without receiver enable");
endmodule
`default_nettype wire

// ===== design/rx_mask_and_no_response_timers.sv
// Design decision made here: the Avalon-MM register port.
`default_nettype none
module rx_mask_and_no_response_timers #(
  parameter int EXIT_SLOW_CYCLES = rx_timer_pkg::EXIT_SLOW_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        txEnd,
  input  wire logic        extFieldOn,
  input  wire logic        peerFieldOn,
  input  wire logic        responseDetected,
  input  wire logic        rxDataIn,
  input  wire logic        corrPulse,
  input  wire logic        rxEnable,
  output logic             rxDataMasked,
  output logic             maskActive,
  output logic             nrtRunning,
  output logic             stream_mode_select,
  output logic             correlatorSleep,
  output logic             irq
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [7:0]  corr2Q;
  logic [7:0]  maskTimeQ;
  logic [7:0]  nrtHighQ;
  logic [7:0]  nrtLowQ;
  logic [7:0]  timerCtrlQ;
  logic [7:0]  modeQ;
  logic [2:0]  statusQ;
  logic [2:0]  irqMaskQ;
  logic [2:0]  events;
  logic [16:0] fcAccQ;
  logic        fcTick;
  logic [17:0] fcSum;
  logic        ackQ;
  logic        wrAck;
  logic        extQ;
  logic        peerQ;
  logic        extRise;
  logic        peerRise;
  logic        startCmd;
  logic        nrtTrigger;
  logic        nrtStart;
  logic [15:0] nrtValue;
  logic [31:0] readdata_d;
  logic        sleepEnter;
  logic        maskWasRunQ;

  timer_if maskBus ();
  timer_if nrtBus ();

  // ---------------------------------------------------------------
  // carrier tick: fractional divider from the core clock
  // ---------------------------------------------------------------
  // the carrier is not an integer fraction of the clock, so ticks
  // jitter by one cycle but average out exactly over time
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      fcAccQ <= 17'h00000;
    else if (fcTick)
      fcAccQ <= 17'(fcSum - {1'b0, rx_timer_pkg::CLK_KHZ});
    else
      fcAccQ <= fcSum[16:0];

  // a spare top bit keeps the sum from wrapping near the top of the range
  assign fcSum  = {1'b0, fcAccQ} + {1'b0, rx_timer_pkg::FC_KHZ};
  assign fcTick = (fcSum >= {1'b0, rx_timer_pkg::CLK_KHZ});

  // ---------------------------------------------------------------
  // bus slave: one wait state on every access
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      ackQ <= 1'b0;
    else
      ackQ <= (read || write) && !ackQ;

  assign waitrequest = (read || write) && !ackQ;
  assign wrAck       = write && ackQ;

  always_comb
  begin
    readdata_d = 32'h00000000;
    case (address)
      {rx_timer_pkg::IDX_CORR2[5:0], 2'b00}:    readdata_d[7:0] = corr2Q;
      {rx_timer_pkg::IDX_MASK[5:0], 2'b00}:     readdata_d[7:0] = maskTimeQ;
      {rx_timer_pkg::IDX_NRT_HI[5:0], 2'b00}:   readdata_d[7:0] = nrtHighQ;
      {rx_timer_pkg::IDX_NRT_LO[5:0], 2'b00}:   readdata_d[7:0] = nrtLowQ;
      {rx_timer_pkg::IDX_TCTRL[5:0], 2'b00}:    readdata_d[7:0] = timerCtrlQ;
      {rx_timer_pkg::IDX_MODE[5:0], 2'b00}:     readdata_d[7:0] = modeQ;
      {rx_timer_pkg::IDX_STATUS[5:0], 2'b00}:   readdata_d[2:0] = statusQ;
      {rx_timer_pkg::IDX_IRQ_MASK[5:0], 2'b00}: readdata_d[2:0] = irqMaskQ;
      {rx_timer_pkg::IDX_STATE[5:0], 2'b00}:
        readdata_d[2:0] = {correlatorSleep, nrtBus.running, maskBus.running};
      default:                                  readdata_d = 32'h00000000;
    endcase
  end

  // data captured in the wait cycle stands at the answering edge
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      readdata <= 32'h00000000;
    else if (read && !ackQ)
      readdata <= readdata_d;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      corr2Q     <= rx_timer_pkg::CORR2_RST;
      maskTimeQ  <= rx_timer_pkg::MASK_RST;
      nrtHighQ   <= rx_timer_pkg::NRT_RST;
      nrtLowQ    <= rx_timer_pkg::NRT_RST;
      timerCtrlQ <= rx_timer_pkg::TCTRL_RST;
      modeQ      <= rx_timer_pkg::MODE_RST;
      irqMaskQ   <= 3'h0;
    end
    else if (wrAck)
    begin
      case (address)
        {rx_timer_pkg::IDX_CORR2[5:0], 2'b00}:    corr2Q <= {6'h00, writedata[1:0]};
        {rx_timer_pkg::IDX_MASK[5:0], 2'b00}:     maskTimeQ <= writedata[7:0];
        {rx_timer_pkg::IDX_NRT_HI[5:0], 2'b00}:   nrtHighQ <= writedata[7:0];
        {rx_timer_pkg::IDX_NRT_LO[5:0], 2'b00}:   nrtLowQ <= writedata[7:0];
        {rx_timer_pkg::IDX_TCTRL[5:0], 2'b00}:    timerCtrlQ <= {4'h0, writedata[3:0]};
        {rx_timer_pkg::IDX_MODE[5:0], 2'b00}:     modeQ <= {5'h00, writedata[2:0]};
        {rx_timer_pkg::IDX_IRQ_MASK[5:0], 2'b00}: irqMaskQ <= writedata[2:0];
        default:                                  modeQ <= modeQ;
      endcase
    end

  // the receiver is told the stream choice as written, software keeps it right
  assign stream_mode_select = corr2Q[rx_timer_pkg::STREAM_BIT];

  assign startCmd = wrAck && (address == {rx_timer_pkg::IDX_COMMAND[5:0], 2'b00})
                    && writedata[rx_timer_pkg::CMD_NRT_BIT];

  // ---------------------------------------------------------------
  // mask receive timer
  // ---------------------------------------------------------------
  assign maskBus.start   = txEnd;
  assign maskBus.abort   = 1'b0;
  assign maskBus.value   = {8'h00, maskTimeQ};
  assign maskBus.stepLen = timerCtrlQ[rx_timer_pkg::MASK_STEP_BIT] ?
                           rx_timer_pkg::MASK_STEP_COARSE :
                           rx_timer_pkg::MASK_STEP_FINE;

  step_timer #(.W(8)) maskTimer (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .fcTick   (fcTick),
    .t        (maskBus.tmr)
  );

  // receiver data is forced low while the mask runs
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      rxDataMasked <= 1'b0;
    else
      rxDataMasked <= rxDataIn && !maskBus.running && !maskBus.start;

  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      maskWasRunQ <= 1'b0;
    else
      maskWasRunQ <= maskBus.running;

  assign maskActive = maskBus.running;

  // ---------------------------------------------------------------
  // no-response timer start conditions
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      extQ  <= 1'b0;
      peerQ <= 1'b0;
    end
    else
    begin
      extQ  <= extFieldOn;
      peerQ <= peerFieldOn;
    end

  assign extRise  = extFieldOn && !extQ;
  assign peerRise = peerFieldOn && !peerQ;
  assign nrtValue = {nrtHighQ, nrtLowQ};

  always_comb
  begin
    if (modeQ[rx_timer_pkg::MODE_NFC_BIT])
      nrtTrigger = extRise;
    else if (modeQ[rx_timer_pkg::MODE_ACTIVE_PEER_TO_PEER_MODE_BIT])
      nrtTrigger = timerCtrlQ[rx_timer_pkg::NRT_COND_BIT] ? peerRise : txEnd;
    else
      nrtTrigger = txEnd;
  end

  assign nrtStart       = (nrtTrigger || startCmd) && (nrtValue != 16'h0000);
  assign nrtBus.start   = nrtStart;
  assign nrtBus.abort   = responseDetected;
  assign nrtBus.value   = nrtValue;
  assign nrtBus.stepLen = timerCtrlQ[rx_timer_pkg::NRT_STEP_BIT] ?
                          rx_timer_pkg::NRT_STEP_COARSE :
                          rx_timer_pkg::NRT_STEP_FINE;

  step_timer #(.W(16)) nrtTimer (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .fcTick   (fcTick),
    .t        (nrtBus.tmr)
  );

  assign nrtRunning = nrtBus.running;

  // ---------------------------------------------------------------
  // correlator sleep
  // ---------------------------------------------------------------
  corr_sleep #(.EXIT_SLOW(EXIT_SLOW_CYCLES)) corrSleep (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .corrPulse  (corrPulse),
    .rxEnable   (rxEnable),
    .exitSel    (corr2Q[rx_timer_pkg::SLEEP_SEL_BIT]),
    .slowStd    (modeQ[rx_timer_pkg::MODE_SLOW_BIT]),
    .sleeping   (correlatorSleep),
    .sleepEnter (sleepEnter)
  );

  // ---------------------------------------------------------------
  // interrupt status, write one to clear, a new event wins
  // ---------------------------------------------------------------
  always_comb
  begin
    events = 3'h0;
    events[rx_timer_pkg::EV_NRT_BIT]   = nrtBus.expire;
    events[rx_timer_pkg::EV_MASK_BIT]  = maskWasRunQ && !maskBus.running;
    events[rx_timer_pkg::EV_SLEEP_BIT] = sleepEnter;
  end

  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      statusQ <= 3'h0;
    else if (wrAck && address == {rx_timer_pkg::IDX_STATUS[5:0], 2'b00})
      statusQ <= (statusQ & ~writedata[2:0]) | events;
    else
      statusQ <= statusQ | events;

  assign irq = |(statusQ & irqMaskQ);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  property p_mask_blanks;
    maskBus.running |=> !rxDataMasked;
  endproperty
  a_mask_blanks: assert property (p_mask_blanks)
    else $error("receiver data passed while masked");

  property p_zero_no_start;
    !nrtBus.running && nrtValue == 16'h0000 |=> !nrtBus.running;
  endproperty
  a_zero_no_start: assert property (p_zero_no_start)
    else $error("no-response timer started with zero timeout");

  property p_cmd_restart;
    startCmd && nrtValue != 16'h0000 && !responseDetected |=> nrtBus.running;
  endproperty
  a_cmd_restart: assert property (p_cmd_restart)
    else $error("start command did not run the timer");

  property p_expiry_irq;
    nrtBus.expire |=> statusQ[rx_timer_pkg::EV_NRT_BIT];
  endproperty
  a_expiry_irq: assert property (p_expiry_irq)
    else $error("timeout did not set the no-response flag");

  property p_nfc_waits_field;
    modeQ[rx_timer_pkg::MODE_NFC_BIT] && !extRise && !startCmd && !nrtBus.running
      |=> !nrtBus.running;
  endproperty
  a_nfc_waits_field: assert property (p_nfc_waits_field)
    else $error("nfc mode timer started without field");

  property p_active_peer_to_peer_mode_txoff;
    modeQ == 8'h02 && !timerCtrlQ[rx_timer_pkg::NRT_COND_BIT] && txEnd
      && nrtValue != 16'h0000 && !responseDetected |=> nrtBus.running;
  endproperty
  a_active_peer_to_peer_mode_txoff: assert property (p_active_peer_to_peer_mode_txoff)
    else $error("active peer timer missed transmitter off");

  property p_fine_step_min;
    $rose(maskBus.running) && maskTimeQ == 8'h01 && !timerCtrlQ[rx_timer_pkg::MASK_STEP_BIT]
      && !txEnd |-> maskBus.running [*8] ##1 maskBus.running;
  endproperty
  a_fine_step_min: assert property (p_fine_step_min)
    else $error("mask step shorter than expected");

  property p_irq_follows;
    statusQ[rx_timer_pkg::EV_NRT_BIT] && irqMaskQ[rx_timer_pkg::EV_NRT_BIT] |-> ##[0:1] irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("unmasked flag without interrupt");

  property p_tick_spacing;
    fcTick |=> !fcTick;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("carrier tick came on two cycles in a row");

  property p_response_stops;
    responseDetected && !nrtStart |=> !nrtBus.running;
  endproperty
  a_response_stops: assert property (p_response_stops)
    else $error("no-response timer kept running after a response");

  c_nrt_expire: cover property (nrtBus.expire);
  c_nrt_abort: cover property (responseDetected && nrtBus.running);
  c_cmd_restart: cover property (startCmd && nrtBus.running);
  c_mask_end: cover property (events[rx_timer_pkg::EV_MASK_BIT]);
  c_sleep_enter: cover property (sleepEnter);
endmodule
`default_nettype wire

// ===== testbench/tb_rx_mask_and_no_response_timers.sv
`default_nettype none
module tb_rx_mask_and_no_response_timers;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic        core_clk = 1'h0;
  logic        reset_n = 1'h0;
  logic [7:0]  address = 8'h00;
  logic        read = 1'h0;
  logic        write = 1'h0;
  logic [31:0] writedata = 32'h0;
  logic        txEnd = 1'h0;
  logic        extFieldOn = 1'h0;
  logic        peerFieldOn = 1'h0;
  logic        responseDetected = 1'h0;
  logic        rxDataIn = 1'h0;
  logic        corrPulse = 1'h0;
  logic        rxEnable = 1'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        rxDataMasked;
  logic        maskActive;
  logic        nrtRunning;
  logic        streamMode;
  logic        correlatorSleep;
  logic        irq;
  int          errors = 0;
  int          total_checks = 0;
  int          n;
  logic [31:0] rd;
  logic [7:0]  adr [9] = '{8'h34, 8'h3C, 8'h40, 8'h44, 8'h48, 8'h60, 8'h64, 8'h68, 8'h00};
  logic [7:0]  rst [9] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  always #4 core_clk = ~core_clk;

  // small slow exit keeps the run short
  rx_mask_and_no_response_timers #(.EXIT_SLOW_CYCLES(20)) u_rx_mask_and_no_response_timers (
    .core_clk(core_clk), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .txEnd(txEnd), .extFieldOn(extFieldOn),
    .peerFieldOn(peerFieldOn), .responseDetected(responseDetected),
    .rxDataIn(rxDataIn), .corrPulse(corrPulse), .rxEnable(rxEnable),
    .rxDataMasked(rxDataMasked), .maskActive(maskActive), .nrtRunning(nrtRunning),
    .stream_mode_select(streamMode), .correlatorSleep(correlatorSleep), .irq(irq)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", errors, total_checks);
    if (errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // carrier tick comes from a fractional divider, so allow a small slack
  task automatic near(input int seen, input int exp);
    check((seen > exp - 12 && seen < exp + 12) ? exp : seen, exp);
  endtask

  function automatic int cyc(input int ticks);
    return ticks * 12500 / 1356;
  endfunction

  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int k;
    @(posedge core_clk);
    address <= a;
    writedata <= {24'h000000, d};
    read <= ~wr;
    write <= wr;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (waitrequest !== 1'h0 && k < 20);
    q = readdata;
    read <= 1'h0;
    write <= 1'h0;
    if (k >= 20)
      errors++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'h1, a, d, rd);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
    bus(1'h0, a, 8'h00, rd);
    check(rd & {24'h000000, mask}, {24'h000000, exp});
  endtask

  function automatic logic sig(input int w);
    case (w)
      0: return maskActive;
      1: return nrtRunning;
      default: return correlatorSleep;
    endcase
  endfunction

  task automatic cnt(input int w, input logic lvl, output int c);
    c = 0;
    do
    begin
      @(posedge core_clk);
      c++;
    end
    while (sig(w) === lvl && c < 60000);
  endtask

  // one-cycle pulse: 0 transmit end, 1 response, 2 correlator pulse
  task automatic kick(input int w);
    @(posedge core_clk);
    txEnd <= (w == 0);
    responseDetected <= (w == 1);
    corrPulse <= (w == 2);
    @(posedge core_clk);
    txEnd <= 1'h0;
    responseDetected <= 1'h0;
    corrPulse <= 1'h0;
  endtask

  task automatic waitn(input int c);
    repeat (c) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'h1;
    foreach (adr[i]) rdchk(adr[i], 8'hFF, rst[i]);
    check({31'h0, irq}, 32'h0);
    kick(2);
    cnt(2, 1'h0, n);
    near(n, 2250);
    cnt(2, 1'h1, n);
    near(n, 2250);
    rdchk(8'h64, 8'h04, 8'h04);
    cnt(2, 1'h0, n);
    wr(8'h34, 8'h03);
    waitn(0);
    check({31'h0, streamMode}, 32'h1);
    waitn(2400);
    check({31'h0, correlatorSleep}, 32'h1);
    rdchk(8'h70, 8'h04, 8'h04);
    @(posedge core_clk);
    rxEnable <= 1'h1;
    @(posedge core_clk);
    rxEnable <= 1'h0;
    waitn(0);
    check({31'h0, correlatorSleep}, 32'h0);
    wr(8'h34, 8'h00);
    wr(8'h60, 8'h04);
    cnt(2, 1'h0, n);
    cnt(2, 1'h1, n);
    near(n, 20);
    wr(8'h60, 8'h00);
    wr(8'h3C, 8'h01);
    wr(8'h68, 8'h03);
    rxDataIn <= 1'h1;
    kick(0);
    waitn(0);
    check({31'h0, rxDataMasked}, 32'h0);
    check({31'h0, nrtRunning}, 32'h0);
    cnt(0, 1'h1, n);
    near(n, cyc(64));
    waitn(3);
    check({31'h0, rxDataMasked}, 32'h1);
    rdchk(8'h64, 8'h03, 8'h02);
    wr(8'h64, 8'hFF);
    waitn(0);
    check({31'h0, irq}, 32'h0);
    wr(8'h48, 8'h08);
    kick(0);
    cnt(0, 1'h1, n);
    near(n, cyc(512));
    wr(8'h48, 8'h00);
    wr(8'h44, 8'h01);
    wr(8'h6C, 8'h01);
    cnt(1, 1'h1, n);
    near(n, cyc(64));
    rdchk(8'h64, 8'h01, 8'h01);
    check({31'h0, irq}, 32'h1);
    wr(8'h64, 8'h07);
    kick(0);
    wr(8'h44, 8'h10);
    cnt(1, 1'h1, n);
    near(n + 3, cyc(64));
    wr(8'h44, 8'h01);
    wr(8'h6C, 8'h01);
    waitn(300);
    wr(8'h6C, 8'h01);
    cnt(1, 1'h1, n);
    near(n, cyc(64));
    wr(8'h64, 8'h07);
    wr(8'h6C, 8'h01);
    waitn(50);
    kick(1);
    waitn(0);
    check({31'h0, nrtRunning}, 32'h0);
    rdchk(8'h64, 8'h01, 8'h00);
    wr(8'h44, 8'h00);
    wr(8'h6C, 8'h01);
    waitn(1);
    check({31'h0, nrtRunning}, 32'h0);
    wr(8'h44, 8'h01);
    wr(8'h48, 8'h01);
    wr(8'h6C, 8'h01);
    cnt(1, 1'h1, n);
    near(n, cyc(4096));
    wr(8'h48, 8'h00);
    wr(8'h60, 8'h01);
    kick(0);
    waitn(1);
    check({31'h0, nrtRunning}, 32'h0);
    @(posedge core_clk);
    extFieldOn <= 1'h1;
    waitn(3);
    check({31'h0, nrtRunning}, 32'h1);
    kick(1);
    extFieldOn <= 1'h0;
    wr(8'h60, 8'h02);
    kick(0);
    waitn(0);
    check({31'h0, nrtRunning}, 32'h1);
    kick(1);
    wr(8'h48, 8'h04);
    kick(0);
    waitn(1);
    check({31'h0, nrtRunning}, 32'h0);
    @(posedge core_clk);
    peerFieldOn <= 1'h1;
    waitn(3);
    check({31'h0, nrtRunning}, 32'h1);
    kick(1);
    peerFieldOn <= 1'h0;
    report_and_stop();
  end

  // a hang shows up as a mismatch, well past the longest expected run
  initial
  begin
    repeat (90000) @(posedge core_clk);
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
